//--- design/sri_pkg.sv
// Purpose: Constants, reset tables and types for the SFR reset initializer.
// Assumes: Each register is 8 bits wide and sits in the low byte of one APB word.
// Notes: Table order is the register index; byte address is four times the index.
package sri_pkg;

    localparam int          NUM_SFR = 32;
    localparam int          ADDR_W  = 8;
    localparam int          PC_W    = 21;
    localparam int          SP_W    = 5;

    // Register indices of the table-driven bank.
    localparam logic [4:0]  IDX_BSR        = 5'h00;
    localparam logic [4:0]  IDX_TIMER0_CONTROL      = 5'h06;
    localparam logic [4:0]  IDX_OSC        = 5'h07;
    localparam logic [4:0]  IDX_RESET_CAUSE_CONTROL       = 5'h0a;
    localparam logic [4:0]  IDX_TIMER1_COUNT_LOW      = 5'h0c;
    localparam logic [4:0]  IDX_ADC1       = 5'h19;
    localparam logic [4:0]  IDX_PA_LATCH   = 5'h1b;
    localparam logic [4:0]  IDX_PA_DIR     = 5'h1c;
    localparam logic [4:0]  IDX_CAN_EXT    = 5'h1d;
    localparam logic [4:0]  IDX_IRQ_EN     = 5'h1e;
    localparam logic [4:0]  IDX_WAKE_FLAGS = 5'h1f;

    // Byte addresses of the return stack view and the port A pins.
    localparam logic [7:0]  ADDR_TOS_UPPER = 8'h80;
    localparam logic [7:0]  ADDR_TOS_HIGH  = 8'h84;
    localparam logic [7:0]  ADDR_TOS_LOW   = 8'h88;
    localparam logic [7:0]  ADDR_STACK_PTR = 8'h8c;
    localparam logic [7:0]  ADDR_PA_INPUT  = 8'h90;

    localparam int          HIGH_PRIORITY_GLOBAL_ENABLE_BIT       = 7;
    localparam int          LOW_PRIORITY_GLOBAL_ENABLE_BIT       = 6;
    localparam int          SOFTWARE_BROWNOUT_ENABLE_BIT     = 6;
    localparam int          WAKE_WDT_BIT   = 7;
    localparam int          SP_FULL_BIT    = 7;
    localparam logic [7:0]  PA_UPPER_MASK  = 8'h3f;
    localparam logic [1:0]  BOR_SW_CFG     = 2'h1;
    localparam logic [1:0]  CAN_MODE_1     = 2'h1;
    localparam logic [1:0]  CAN_MODE_2     = 2'h2;
    localparam logic [4:0]  SP_MAX         = 5'h1f;
    localparam logic [20:0] VEC_HIGH       = 21'h000008;
    localparam logic [20:0] VEC_LOW        = 21'h000018;
    localparam logic [20:0] PC_STEP        = 21'h000002;

    // Condition-driven bit masks per reset class.
    localparam logic [7:0]  OSC_COND_POWER = 8'h08;
    localparam logic [7:0]  OSC_COND_OTHER = 8'h02;
    localparam logic [7:0]  RESET_CAUSE_CONTROL_COND_POWER = 8'h42;
    localparam logic [7:0]  RESET_CAUSE_CONTROL_COND_WARM = 8'h5c;
    localparam logic [7:0]  RESET_CAUSE_CONTROL_COND_WAKE = 8'h4c;
    localparam logic [7:0]  ADC1_COND      = 8'h07;

    localparam logic [7:0] SFR_IMPL [NUM_SFR] = '{
        8'h0f, 8'h0f, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hbf, 8'h01, 8'hdf, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h3f, 8'h3f, 8'hbf, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [7:0] SFR_POWER_VAL [NUM_SFR] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h40,
        8'h05, 8'h00, 8'h1c, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] SFR_POWER_KEEP [NUM_SFR] = '{
        8'h00, 8'h00, 8'hff, 8'h1f, 8'h00, 8'hff, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    localparam logic [7:0] SFR_WARM_VAL [NUM_SFR] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h40,
        8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] SFR_WARM_KEEP [NUM_SFR] = '{
        8'h00, 8'h00, 8'hff, 8'h1f, 8'h00, 8'hff, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h03, 8'hff, 8'hff, 8'hbf, 8'h00, 8'h00,
        8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
        8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h01, 8'h00};
    localparam logic [7:0] SFR_WAKE_VAL [NUM_SFR] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] SFR_WAKE_KEEP [NUM_SFR] = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfd,
        8'h3f, 8'hff, 8'h93, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    typedef enum logic [1:0] {CLS_POWER, CLS_WARM, CLS_WAKE} sri_cls_t;
    typedef enum logic [1:0] {CAUSE_PIN, CAUSE_WDT, CAUSE_INSTR, CAUSE_STACK} sri_cause_t;
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SETTLE} sri_state_t;

endpackage

//--- design/sri_stack_ram.sv
// Purpose: Return stack storage with one write port and a registered read port.
// Assumes: Write and read addresses are within the depth.
// Notes: Read data lags the address by one clock.
`timescale 1ns/1ps
module sri_stack_ram #(
    parameter int DEPTH  = 32,
    parameter int WIDTH  = 21,
    parameter int AW     = 5
) (
    input  wire logic             core_clk,
    input  wire logic             clk_en,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

//--- design/sri_top.sv
// Purpose: Loads the special function register bank according to the reset class and serves it over APB.
// Assumes: Reset and wake-up events are one-cycle pulses synchronous to core_clk.
// Notes: Instruction fetch is held off until the class values have been loaded.
`timescale 1ns/1ps
// How it works
// - Reset value chosen by one of three classes.
// - Unchanged bits keep; unknown bits may be anything.
// - Unimplemented bits always read zero.
// - Conditional bits loaded from cause or configuration.
// - Wake-up sets a flag for its source.
// - Interrupt wake with enable loads the vector.
// - Interrupt wake with enable copies PC into stack top.
// - Interrupt wake with enable advances the stack pointer; at the top it sets the full bit instead.
// - Port A bits 6-7 exist only when freed.
// - Extended controller register reads zero outside modes 1-2.
// - Software brown-out bit: one at power-on only with the software brown-out config, else keep/zero.
module sri_top
    import sri_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              power_on_event,
    input  wire logic              brownout_event,
    input  wire logic              warm_event,
    input  wire logic [1:0]        warm_cause,
    input  wire logic              wake_wdt_event,
    input  wire logic              wake_irq_event,
    input  wire logic [2:0]        wake_src,
    input  wire logic              wake_high_prio,
    input  wire logic [1:0]        brownout_config_field,
    input  wire logic              osc_startup_done,
    input  wire logic              osc_source_stable,
    input  wire logic [2:0]        adc_config,
    input  wire logic              osc_frees_pins,
    input  wire logic [1:0]        can_mode,
    input  wire logic [7:0]        port_a_pins,
    input  wire logic [PC_W-1:0]   pc_current,
    output logic                   pc_load,
    output logic      [PC_W-1:0]   pc_load_value,
    output logic                   fetch_enable,
    input  wire logic [SP_W-1:0]   stack_rd_addr,
    output logic      [PC_W-1:0]   stack_rd_data
);
    sri_state_t       state_reg;
    sri_state_t       state_next;
    sri_cls_t         cls_reg;
    sri_cause_t       cause_reg;
    logic             power_on_reg;
    logic             irq_wake_reg;
    logic [2:0]       src_reg;
    logic             high_prio_reg;
    logic [7:0]       sfr_reg [NUM_SFR];
    logic [7:0]       load_val [NUM_SFR];
    logic [7:0]       cond_mask [NUM_SFR];
    logic [7:0]       cond_val [NUM_SFR];
    logic [PC_W-1:0]  tos_reg;
    logic [7:0]       stack_ptr_reg;
    logic [31:0]      prdata_reg;
    logic [7:0]       rd_mux;
    logic [7:0]       wake_set;
    logic             any_event;
    logic             is_load;
    logic             gie;
    logic             push;
    logic             sw_bor_cfg;
    logic             sbor_keep;
    logic             access;
    logic             wr_en;
    logic             is_table;
    logic             mapped;
    logic [4:0]       idx;
    logic [7:0]       pa_gate;
    logic             can_active;

    assign any_event = power_on_event | brownout_event | warm_event | wake_wdt_event | wake_irq_event;
    assign is_load   = (state_reg == ST_LOAD);
    assign gie       = sfr_reg[IDX_IRQ_EN][HIGH_PRIORITY_GLOBAL_ENABLE_BIT] | sfr_reg[IDX_IRQ_EN][LOW_PRIORITY_GLOBAL_ENABLE_BIT];
    assign push      = (cls_reg == CLS_WAKE) && irq_wake_reg && gie;
    assign sw_bor_cfg = (brownout_config_field == BOR_SW_CFG);
    assign sbor_keep = sw_bor_cfg & sfr_reg[IDX_RESET_CAUSE_CONTROL][SOFTWARE_BROWNOUT_ENABLE_BIT];
    assign pa_gate   = osc_frees_pins ? 8'hff : PA_UPPER_MASK;
    assign can_active = (can_mode == CAN_MODE_1) || (can_mode == CAN_MODE_2);
    assign fetch_enable = (state_reg == ST_IDLE) && !any_event;
    assign pc_load   = (state_reg == ST_SETTLE);

    // A newer event always restarts loading, strongest class first.
    always_comb begin
        case (state_reg)
            ST_IDLE:   state_next = ST_IDLE;
            ST_LOAD:   state_next = ST_SETTLE;
            ST_SETTLE: state_next = ST_IDLE;
            default:   state_next = ST_IDLE;
        endcase
        if (any_event) begin
            state_next = ST_LOAD;
        end
    end

    // Coming out of sys_rst is handled as a power-on load.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_LOAD;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cls_reg       <= CLS_POWER;
            cause_reg     <= CAUSE_PIN;
            power_on_reg  <= 1'b1;
            irq_wake_reg  <= 1'b0;
            src_reg       <= 3'h0;
            high_prio_reg <= 1'b0;
        end else if (clk_en && any_event) begin
            power_on_reg  <= power_on_event;
            cause_reg     <= sri_cause_t'(warm_cause);
            irq_wake_reg  <= wake_irq_event;
            src_reg       <= wake_src;
            high_prio_reg <= wake_high_prio;
            if (power_on_event || brownout_event) begin
                cls_reg <= CLS_POWER;
            end else if (warm_event) begin
                cls_reg <= CLS_WARM;
            end else begin
                cls_reg <= CLS_WAKE;
            end
        end
    end

    // Condition-driven bits come from the latched cause or the configuration inputs.
    always_comb begin
        for (int i = 0; i < NUM_SFR; i++) begin
            cond_mask[i] = 8'h00;
            cond_val[i]  = 8'h00;
        end
        case (cls_reg)
            CLS_POWER: begin
                cond_mask[IDX_OSC]  = OSC_COND_POWER;
                cond_val[IDX_OSC]   = {4'h0, osc_startup_done, 3'h0};
                cond_mask[IDX_RESET_CAUSE_CONTROL] = RESET_CAUSE_CONTROL_COND_POWER;
                cond_val[IDX_RESET_CAUSE_CONTROL]  = {1'b0, sw_bor_cfg, 4'h0, !power_on_reg, 1'b0};
                cond_mask[IDX_ADC1] = ADC1_COND;
                cond_val[IDX_ADC1]  = {5'h00, adc_config};
            end
            CLS_WARM: begin
                cond_mask[IDX_OSC]  = OSC_COND_OTHER;
                cond_val[IDX_OSC]   = {6'h00, osc_source_stable, 1'b0};
                cond_mask[IDX_RESET_CAUSE_CONTROL] = RESET_CAUSE_CONTROL_COND_WARM;
                cond_val[IDX_RESET_CAUSE_CONTROL]  = {1'b0, sbor_keep, 1'b0, cause_reg != CAUSE_INSTR,
                                       cause_reg != CAUSE_WDT, 1'b1, 2'h0};
                cond_mask[IDX_ADC1] = ADC1_COND;
                cond_val[IDX_ADC1]  = {5'h00, adc_config};
            end
            CLS_WAKE: begin
                cond_mask[IDX_OSC]  = OSC_COND_OTHER;
                cond_val[IDX_OSC]   = {6'h00, osc_source_stable, 1'b0};
                cond_mask[IDX_RESET_CAUSE_CONTROL] = RESET_CAUSE_CONTROL_COND_WAKE;
                cond_val[IDX_RESET_CAUSE_CONTROL]  = {1'b0, sbor_keep, 2'h0, irq_wake_reg, 1'b0, 2'h0};
            end
            default: begin
                cond_mask[IDX_OSC]  = 8'h00;
            end
        endcase
    end

    // Each entry keeps its unchanged bits, takes its class constant and its conditional bits.
    for (genvar i = 0; i < NUM_SFR; i++) begin : g_load
        logic [7:0] val;
        logic [7:0] keep;
        assign val  = (cls_reg == CLS_POWER) ? SFR_POWER_VAL[i] :
                      (cls_reg == CLS_WARM)  ? SFR_WARM_VAL[i] : SFR_WAKE_VAL[i];
        assign keep = (cls_reg == CLS_POWER) ? SFR_POWER_KEEP[i] :
                      (cls_reg == CLS_WARM)  ? SFR_WARM_KEEP[i] : SFR_WAKE_KEEP[i];
        assign load_val[i] = (((sfr_reg[i] & keep) | (val & ~keep)) & ~cond_mask[i]
                             | (cond_val[i] & cond_mask[i])) & SFR_IMPL[i];
    end

    assign wake_set = (cls_reg != CLS_WAKE) ? 8'h00 :
                      irq_wake_reg ? (8'h01 << src_reg) : (8'h01 << WAKE_WDT_BIT);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_SFR; i++) begin
                sfr_reg[i] <= 8'h00;
            end
        end else if (clk_en) begin
            if (is_load) begin
                for (int i = 0; i < NUM_SFR; i++) begin
                    sfr_reg[i] <= load_val[i];
                end
                sfr_reg[IDX_WAKE_FLAGS] <= load_val[IDX_WAKE_FLAGS] | wake_set;
            end else if (wr_en && is_table) begin
                if (idx == IDX_PA_LATCH || idx == IDX_PA_DIR) begin
                    sfr_reg[idx] <= pwdata[7:0] & SFR_IMPL[idx] & pa_gate;
                end else begin
                    sfr_reg[idx] <= pwdata[7:0] & SFR_IMPL[idx];
                end
            end
        end
    end

    // Return stack: an interrupt wake with a global enable pushes the current PC.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tos_reg       <= '0;
            stack_ptr_reg <= 8'h00;
        end else if (clk_en && is_load) begin
            if (cls_reg == CLS_POWER) begin
                tos_reg       <= '0;
                stack_ptr_reg <= 8'h00;
            end else if (cls_reg == CLS_WARM) begin
                tos_reg       <= '0;
                stack_ptr_reg <= {stack_ptr_reg[7:6], 6'h00};
            end else if (push) begin
                tos_reg <= pc_current;
                if (stack_ptr_reg[SP_W-1:0] == SP_MAX) begin
                    stack_ptr_reg[SP_FULL_BIT] <= 1'b1;
                end else begin
                    stack_ptr_reg[SP_W-1:0] <= stack_ptr_reg[SP_W-1:0] + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_load_value <= '0;
        end else if (clk_en && is_load) begin
            if (cls_reg != CLS_WAKE) begin
                pc_load_value <= '0;
            end else if (push) begin
                pc_load_value <= high_prio_reg ? VEC_HIGH : VEC_LOW;
            end else begin
                pc_load_value <= pc_current + PC_STEP;
            end
        end
    end

    sri_stack_ram #(
        .DEPTH (32),
        .WIDTH (PC_W),
        .AW    (SP_W)
    ) u_stack (
        .core_clk (core_clk),
        .clk_en   (clk_en),
        .wr_en    (is_load && push && stack_ptr_reg[SP_W-1:0] != SP_MAX),
        .wr_addr  (stack_ptr_reg[SP_W-1:0] + 5'h01),
        .wr_data  (pc_current),
        .rd_addr  (stack_rd_addr),
        .rd_data  (stack_rd_data)
    );

    // APB slave: the bank is held off while a class is being loaded.
    assign access   = psel && penable;
    assign pready   = (state_reg == ST_IDLE);
    assign idx      = paddr[6:2];
    assign is_table = !paddr[7] && (paddr[1:0] == 2'h0);
    assign mapped   = is_table || paddr == ADDR_TOS_UPPER || paddr == ADDR_TOS_HIGH
                      || paddr == ADDR_TOS_LOW || paddr == ADDR_STACK_PTR || paddr == ADDR_PA_INPUT;
    assign wr_en    = access && pwrite && pready;
    assign pslverr  = access && pready && !mapped;

    always_comb begin
        rd_mux = 8'h00;
        if (is_table) begin
            rd_mux = sfr_reg[idx] & SFR_IMPL[idx];
            if (idx == IDX_PA_LATCH || idx == IDX_PA_DIR) begin
                rd_mux = rd_mux & pa_gate;
            end
            if (idx == IDX_CAN_EXT && !can_active) begin
                rd_mux = 8'h00;
            end
        end else begin
            case (paddr)
                ADDR_TOS_UPPER: rd_mux = {3'h0, tos_reg[20:16]};
                ADDR_TOS_HIGH:  rd_mux = tos_reg[15:8];
                ADDR_TOS_LOW:   rd_mux = tos_reg[7:0];
                ADDR_STACK_PTR: rd_mux = stack_ptr_reg & 8'hdf;
                ADDR_PA_INPUT:  rd_mux = port_a_pins & pa_gate;
                default:        rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= 32'h0;
        end else if (clk_en && psel) begin
            prdata_reg <= {24'h0, rd_mux};
        end
    end
    assign prdata = prdata_reg;

    a_fetch_held: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg != ST_IDLE) |-> !fetch_enable && !pready)
        else $error("fetch allowed while loading");
    a_bsr_upper: assert property (@(posedge core_clk) disable iff (sys_rst)
        sfr_reg[IDX_BSR][7:4] == 4'h0)
        else $error("unimplemented bank select bits set");
    a_power_class: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_load && clk_en && cls_reg == CLS_POWER) |=> sfr_reg[IDX_TIMER0_CONTROL] == 8'hff && tos_reg == '0)
        else $error("power class value not loaded");
    a_warm_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_load && clk_en && cls_reg == CLS_WARM) |=> sfr_reg[IDX_TIMER1_COUNT_LOW] == $past(sfr_reg[IDX_TIMER1_COUNT_LOW]))
        else $error("unchanged bits lost on warm reset");
    a_osc_cond: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_load && clk_en && cls_reg == CLS_POWER) |=> sfr_reg[IDX_OSC][3] == $past(osc_startup_done))
        else $error("conditional oscillator bit wrong");
    a_wake_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_load && clk_en && cls_reg == CLS_WAKE) |=> sfr_reg[IDX_WAKE_FLAGS] != 8'h00)
        else $error("wake-up left no flag");
    a_wake_vector: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_load && clk_en && push) |=> pc_load_value == ($past(high_prio_reg) ? VEC_HIGH : VEC_LOW)
        && pc_load)
        else $error("vector not loaded on interrupt wake");
    a_tos_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_load && clk_en && push) |=> tos_reg == $past(pc_current))
        else $error("stack top not loaded with PC");
    a_ptr_step: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_load && clk_en && push && stack_ptr_reg[4:0] != SP_MAX)
        |=> stack_ptr_reg[4:0] == $past(stack_ptr_reg[4:0]) + 5'h01)
        else $error("stack pointer did not advance");
    a_port_a_input_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!osc_frees_pins && paddr == ADDR_PA_INPUT) |-> rd_mux[7:6] == 2'h0)
        else $error("port A upper bits visible");
    a_can_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!can_active && is_table && idx == IDX_CAN_EXT) |-> rd_mux == 8'h00)
        else $error("extended controller register not zero");
    a_sbor_power: assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_load && clk_en && cls_reg == CLS_POWER) |=> sfr_reg[IDX_RESET_CAUSE_CONTROL][SOFTWARE_BROWNOUT_ENABLE_BIT] == $past(sw_bor_cfg))
        else $error("software brown-out bit wrong after power-on");
endmodule

//--- verification/sri_tb.sv
// Purpose: Self-checking bench for the reset initializer register bank over APB.
// Assumes: Events are one-cycle pulses; the bank answers once pready is high.
// Notes: Random data come from a fixed seed; hand-picked corners sit among them.
`timescale 1ns/1ps
module testbench
    import sri_pkg::*;
;
    logic              core_clk = 0, sys_rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic              power_on_event = 0, brownout_event = 0, warm_event = 0, wake_wdt_event = 0;
    logic              wake_irq_event = 0, wake_high_prio = 0, osc_startup_done = 1, osc_source_stable = 1;
    logic              osc_frees_pins = 0, pready, pslverr, pc_load, fetch_enable, err;
    logic [7:0]        paddr = 0, port_a_pins = 0, d, d2;
    logic [31:0]       pwdata = 0, prdata, r;
    logic [1:0]        warm_cause = 0, brownout_config_field = 0, can_mode = 0;
    logic [2:0]        wake_src = 0, adc_config = 0;
    logic [PC_W-1:0]   pc_current = 0, pc_load_value, stack_rd_data, pcv;
    logic [SP_W-1:0]   stack_rd_addr = 5'h01;
    logic [7:0]        ra [5] = '{8'h00, 8'h18, 8'h20, 8'h3c, 8'h8c};
    logic [7:0]        rv [5] = '{8'h00, 8'hff, 8'h05, 8'hff, 8'h00};
    integer            seed = 32'hf4af1e5f, fail_count = 0, n_tests = 0, cyc = 0;

    always #4 core_clk = ~core_clk;

    sri_top u_sri_top (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_on_event(power_on_event), .brownout_event(brownout_event), .warm_event(warm_event),
        .warm_cause(warm_cause), .wake_wdt_event(wake_wdt_event), .wake_irq_event(wake_irq_event),
        .wake_src(wake_src), .wake_high_prio(wake_high_prio), .brownout_config_field(brownout_config_field),
        .osc_startup_done(osc_startup_done), .osc_source_stable(osc_source_stable), .adc_config(adc_config),
        .osc_frees_pins(osc_frees_pins), .can_mode(can_mode), .port_a_pins(port_a_pins),
        .pc_current(pc_current), .pc_load(pc_load), .pc_load_value(pc_load_value), .fetch_enable(fetch_enable),
        .stack_rd_addr(stack_rd_addr), .stack_rd_data(stack_rd_data));

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 8'h00);
        chk(r, exp, m);
    endtask

    // Fires one event (0 warm, 1 irq wake, 2 watchdog wake, 3 brown-out, 4 power-on) and captures the load pulse.
    task pulse(input int k);
        @(posedge core_clk);
        power_on_event <= (k == 4);
        warm_event <= (k == 0);
        wake_irq_event <= (k == 1);
        wake_wdt_event <= (k == 2);
        brownout_event <= (k == 3);
        @(posedge core_clk);
        {power_on_event, warm_event, wake_irq_event, wake_wdt_event, brownout_event} <= 5'h00;
        for (int i = 0; i < 10 && fetch_enable !== 1'b1; i++) begin
            @(posedge core_clk);
            if (pc_load === 1'b1) begin
                pcv = pc_load_value;
                chk(fetch_enable, 32'h0, "fetch while loading");
            end
        end
    endtask

    task report_and_stop;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            $display("mismatch at %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(ra[i], {24'h0, rv[i]}, "power-on value");
        repeat (3) begin
            d = $random(seed);
            d2 = $random(seed);
            adc_config <= d2[2:0];
            warm_cause <= d[1:0];
            apb(1'b1, 8'h00, d);
            rd_chk(8'h00, {24'h0, d & 8'h0f}, "bank select width");
            apb(1'b1, 8'h2c, d2);
            apb(1'b1, 8'h3c, d);
            pulse(2);
            rd_chk(8'h00, {24'h0, d & 8'h0f}, "bank select kept on wake");
            rd_chk(8'h3c, 32'hff, "timer2 period on wake");
            apb(1'b0, 8'h7c, 8'h00);
            chk(r[WAKE_WDT_BIT], 32'h1, "watchdog wake flag");
            pulse(0);
            rd_chk(8'h00, 32'h0, "bank select on warm reset");
            rd_chk(8'h2c, {24'h0, d2}, "timer1 kept on warm reset");
            rd_chk(8'h64, {29'h0, d2[2:0]}, "converter config bits");
        end
        pc_current <= 21'($random(seed));
        wake_src <= 3'($random(seed));
        wake_high_prio <= 1'b1;
        apb(1'b1, 8'h78, 8'h80);
        pulse(1);
        chk(pcv, VEC_HIGH, "interrupt vector");
        rd_chk(8'h80, {27'h0, pc_current[20:16]}, "stack top upper");
        rd_chk(8'h84, {24'h0, pc_current[15:8]}, "stack top high");
        rd_chk(8'h88, {24'h0, pc_current[7:0]}, "stack top low");
        chk(stack_rd_data, pc_current, "stack entry");
        apb(1'b0, 8'h8c, 8'h00);
        chk(r[4:0], 32'h1, "stack pointer advance");
        apb(1'b0, 8'h7c, 8'h00);
        chk(r[wake_src], 32'h1, "interrupt wake flag");
        port_a_pins <= 8'($random(seed));
        apb(1'b1, 8'h6c, 8'hff);
        rd_chk(8'h6c, 32'h3f, "port latch upper bits");
        rd_chk(8'h90, {24'h0, port_a_pins & PA_UPPER_MASK}, "port input upper bits");
        osc_frees_pins <= 1'b1;
        apb(1'b1, 8'h6c, 8'hff);
        rd_chk(8'h6c, 32'hff, "port latch freed");
        apb(1'b1, 8'h74, 8'ha5);
        rd_chk(8'h74, 32'h0, "extended register off");
        can_mode <= CAN_MODE_2;
        apb(1'b1, 8'h74, 8'ha5);
        rd_chk(8'h74, 32'ha5, "extended register on");
        apb(1'b0, 8'ha0, 8'h00);
        chk(err, 32'h1, "unmapped error");
        chk(r, 32'h0, "unmapped read");
        apb(1'b1, 8'h00, 8'h05);
        pulse(3);
        rd_chk(8'h00, 32'h0, "bank select on brown-out");
        rd_chk(8'h28, 32'h1e, "reset cause after brown-out");
        brownout_config_field <= BOR_SW_CFG;
        pulse(4);
        rd_chk(8'h28, 32'h5c, "reset cause after power-on");
        report_and_stop();
    end
endmodule
